/* File: hdl/tmrc_defines.vh */
// tmrc_defines.vh: register offsets, field positions, reset values and mode codes
// for the timer mode and run control block.
// assumes: included by the block's design files by bare name, definitions only.
`ifndef TMRC_DEFINES_VH
`define TMRC_DEFINES_VH

// ==============================================================
// register offsets (byte addresses on the register port)
`define TMRC_OFS_CTRL01 8'h88
`define TMRC_OFS_MODE01 8'h89
`define TMRC_OFS_CON34 8'h90
`define TMRC_OFS_MODE34 8'h91
`define TMRC_OFS_T0_LO 8'ha0
`define TMRC_OFS_T0_HI 8'ha1
`define TMRC_OFS_T1_LO 8'ha2
`define TMRC_OFS_T1_HI 8'ha3
`define TMRC_OFS_T3_LO 8'ha4
`define TMRC_OFS_T3_HI 8'ha5
`define TMRC_OFS_T4_LO 8'ha6
`define TMRC_OFS_T4_HI 8'ha7
`define TMRC_OFS_IRQ_STAT 8'ha8
`define TMRC_OFS_IRQ_CLR 8'ha9
`define TMRC_OFS_IRQ_EN 8'haa

// ==============================================================
// field positions: run and flag control (both control registers share them), sub clock selects (timer 3/4 register only)
`define TMRC_BIT_TF_HI 7
`define TMRC_BIT_TR_HI 6
`define TMRC_BIT_TF_LO 5
`define TMRC_BIT_TR_LO 4
`define TMRC_BIT_SUB_THIRD 2
`define TMRC_BIT_SUB_FOURTH 0

// field positions inside one 4-bit mode nibble
`define TMRC_BIT_GATE 3
`define TMRC_BIT_CT 2

// ==============================================================
// mode codes of the two-bit mode field
`define TMRC_MODE_13BIT 2'b00
`define TMRC_MODE_16BIT 2'b01
`define TMRC_MODE_RELOAD 2'b10
`define TMRC_MODE_SPLIT 2'b11

// ==============================================================
// reset values
`define TMRC_RST_BYTE 8'h00
`define TMRC_RST_NIB 4'h0
`define TMRC_RST_CNT 16'h0000

`endif

/* File: hdl/tmrc_pair.v */
// tmrc_pair.v: one pair of 16-bit timer/counters, a lower (0 or 3) and an upper
// (1 or 4), with the three counting modes and the split mode of the lower one.
// assumes: all pins synchronous to clk_in; byte writes come from the register port.
`timescale 1ns/100ps
`include "tmrc_defines.vh"

module tmrc_pair (
  // clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // mode nibbles {gate, counter select, mode_field_high, mode_field_low}
  input wire [3:0] mode_lo_in,
  input wire [3:0] mode_hi_in,
  // run bits, gate pins, count pins and time base ticks
  input wire run_lo_in,
  input wire run_hi_in,
  input wire gate_pin_lo_in,
  input wire gate_pin_hi_in,
  input wire count_pin_lo_in,
  input wire count_pin_hi_in,
  input wire tick_lo_in,
  input wire tick_hi_in,
  // byte writes: bit0 lower.low, bit1 lower.high, bit2 upper.low, bit3 upper.high
  input wire [3:0] wr_byte_in,
  input wire [7:0] wr_data_in,
  // counts and overflow pulses
  output wire [15:0] count_lo_out,
  output wire [15:0] count_hi_out,
  output reg ovf_lo_out,
  output reg ovf_hi_out
);

  // ==============================================================
  // one counting step in modes 0..2; returns {overflow, next count}
  function [16:0] tmrc_step;
    input [1:0] mode;
    input [15:0] cnt;
    reg [5:0] pre;
    reg [8:0] hi9;
    reg [8:0] lo9;
    begin
      pre = {1'b0, cnt[4:0]} + 6'h01;
      hi9 = {1'b0, cnt[15:8]} + {8'h00, pre[5]};
      lo9 = {1'b0, cnt[7:0]} + 9'h001;
      case (mode)
        `TMRC_MODE_13BIT: begin
          // five-bit prescaler in the low byte carries into the high byte
          tmrc_step = {hi9[8], hi9[7:0], cnt[7:5], pre[4:0]};
        end
        `TMRC_MODE_16BIT: begin
          tmrc_step = {1'b0, cnt} + 17'h00001;
        end
        `TMRC_MODE_RELOAD: begin
          // low byte reloads from the high byte on its overflow
          if (lo9[8]) begin
            tmrc_step = {1'b1, cnt[15:8], cnt[15:8]};
          end else begin
            tmrc_step = {1'b0, cnt[15:8], lo9[7:0]};
          end
        end
        default: begin
          tmrc_step = {1'b0, cnt};
        end
      endcase
    end
  endfunction

  reg [15:0] cnt_lo_r;
  reg [15:0] cnt_hi_r;
  reg [15:0] cnt_lo_nxt;
  reg [15:0] cnt_hi_nxt;
  reg pin_lo_r;
  reg pin_hi_r;
  reg ovf_lo_nxt;
  reg ovf_hi_nxt;
  reg [16:0] step_lo;
  reg [16:0] step_hi;
  reg [8:0] split_lo9;
  reg [8:0] split_hi9;

  // ==============================================================
  // count events and enables
  wire split_w = (mode_lo_in[1:0] == `TMRC_MODE_SPLIT);
  // counter mode counts a 1-to-0 step of the count pin, timer mode the time base
  wire ev_lo_w = mode_lo_in[`TMRC_BIT_CT] ? (pin_lo_r & ~count_pin_lo_in) : tick_lo_in;
  wire ev_hi_w = mode_hi_in[`TMRC_BIT_CT] ? (pin_hi_r & ~count_pin_hi_in) : tick_hi_in;
  // gate 1: run bit and pin both needed; gate 0: run bit alone
  wire go_lo_w = run_lo_in & (~mode_lo_in[`TMRC_BIT_GATE] | gate_pin_lo_in);
  wire go_hi_w = run_hi_in & (~mode_hi_in[`TMRC_BIT_GATE] | gate_pin_hi_in);
  wire en_lo_w = go_lo_w & ev_lo_w;
  // upper pair member holds its count in mode 3
  wire en_hi_w = go_hi_w & ev_hi_w & (mode_hi_in[1:0] != `TMRC_MODE_SPLIT);
  // split high byte: timer only, under the upper member's run bit
  wire en_split_w = run_hi_in & tick_hi_in;

  // ==============================================================
  // next counts; register writes win over counting in the same cycle
  always @* begin
    step_lo = tmrc_step(mode_lo_in[1:0], cnt_lo_r);
    step_hi = tmrc_step(mode_hi_in[1:0], cnt_hi_r);
    split_lo9 = {1'b0, cnt_lo_r[7:0]} + 9'h001;
    split_hi9 = {1'b0, cnt_lo_r[15:8]} + 9'h001;
    cnt_lo_nxt = cnt_lo_r;
    cnt_hi_nxt = cnt_hi_r;
    ovf_lo_nxt = 1'b0;
    ovf_hi_nxt = 1'b0;
    if (split_w) begin
      if (en_lo_w) begin
        cnt_lo_nxt[7:0] = split_lo9[7:0];
        ovf_lo_nxt = split_lo9[8];
      end
      if (en_split_w) begin
        cnt_lo_nxt[15:8] = split_hi9[7:0];
        ovf_hi_nxt = split_hi9[8];
      end
    end else if (en_lo_w) begin
      cnt_lo_nxt = step_lo[15:0];
      ovf_lo_nxt = step_lo[16];
    end
    if (en_hi_w) begin
      cnt_hi_nxt = step_hi[15:0];
      // the split high byte owns the upper flag while the lower one is split
      ovf_hi_nxt = ovf_hi_nxt | (step_hi[16] & ~split_w);
    end
    if (wr_byte_in[0]) cnt_lo_nxt[7:0] = wr_data_in;
    if (wr_byte_in[1]) cnt_lo_nxt[15:8] = wr_data_in;
    if (wr_byte_in[2]) cnt_hi_nxt[7:0] = wr_data_in;
    if (wr_byte_in[3]) cnt_hi_nxt[15:8] = wr_data_in;
  end

  // ==============================================================
  // state registers
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_lo_r <= `TMRC_RST_CNT;
      cnt_hi_r <= `TMRC_RST_CNT;
      pin_lo_r <= 1'b0;
      pin_hi_r <= 1'b0;
      ovf_lo_out <= 1'b0;
      ovf_hi_out <= 1'b0;
    end else begin
      cnt_lo_r <= cnt_lo_nxt;
      cnt_hi_r <= cnt_hi_nxt;
      pin_lo_r <= count_pin_lo_in;
      pin_hi_r <= count_pin_hi_in;
      ovf_lo_out <= ovf_lo_nxt;
      ovf_hi_out <= ovf_hi_nxt;
    end
  end

  assign count_lo_out = cnt_lo_r;
  assign count_hi_out = cnt_hi_r;

endmodule // tmrc_pair

/* File: hdl/tmrc_top.v */
// tmrc_top.v: mode and run control for timer/counters 0, 1, 3 and 4, with the
// register port, overflow flags, sub clock selects and the interrupt output.
// assumes: one clock, all inputs synchronous to it, a single register master.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "tmrc_defines.vh"

module tmrc_top (
  // clock and reset
  input wire sys_clk_in,
  input wire arst_n_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // pins, index 0 timer0, 1 timer1, 2 timer3, 3 timer4
  input wire [3:0] external_interrupt_pin_in,
  input wire [3:0] count_pin_in,
  input wire sub_osc_in,
  // vectoring acknowledge per timer, one-cycle pulse
  input wire [3:0] vec_ack_in,
  // flags and interrupt
  output reg [3:0] ovf_flag_out,
  output reg irq_out
);

  // ==============================================================
  // control registers
  reg [7:0] mode01_r;
  reg [7:0] mode34_r;
  reg run_bit_zero_r;
  reg run_bit_one_r;
  reg run_bit_third_r;
  reg run_bit_fourth_r;
  reg sub_osc_select_third_r;
  reg sub_osc_select_fourth_r;
  reg [3:0] flag_r;
  reg [3:0] flag_nxt;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_stat_nxt;
  reg [3:0] irq_en_r;
  reg sub_prev_r;
  reg [7:0] rd_val;

  wire [15:0] cnt0_w;
  wire [15:0] cnt1_w;
  wire [15:0] cnt3_w;
  wire [15:0] cnt4_w;
  wire ovf0_w;
  wire ovf1_w;
  wire ovf3_w;
  wire ovf4_w;
  wire [3:0] ovf_w = {ovf4_w, ovf3_w, ovf1_w, ovf0_w};

  // ==============================================================
  // write decode
  wire wr_ctrl01_w = reg_wr_in & (reg_addr_in == `TMRC_OFS_CTRL01);
  wire wr_mode01_w = reg_wr_in & (reg_addr_in == `TMRC_OFS_MODE01);
  wire wr_con34_w = reg_wr_in & (reg_addr_in == `TMRC_OFS_CON34);
  wire wr_mode34_w = reg_wr_in & (reg_addr_in == `TMRC_OFS_MODE34);
  wire wr_clr_w = reg_wr_in & (reg_addr_in == `TMRC_OFS_IRQ_CLR);
  wire wr_en_w = reg_wr_in & (reg_addr_in == `TMRC_OFS_IRQ_EN);
  wire [3:0] wr_b01_w;
  wire [3:0] wr_b34_w;

  // count byte strobes, low byte then high byte of each timer
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_wr
      assign wr_b01_w[gi] = reg_wr_in & (reg_addr_in == (`TMRC_OFS_T0_LO + gi[7:0]));
      assign wr_b34_w[gi] = reg_wr_in & (reg_addr_in == (`TMRC_OFS_T3_LO + gi[7:0]));
    end
  endgenerate

  // ==============================================================
  // time base for timers 3 and 4
  // the sub oscillator is sampled on the system clock, so it must run well
  // below half the system clock rate; each rising step gives one tick
  wire sub_tick_w = sub_osc_in & ~sub_prev_r;
  wire tick3_w = sub_osc_select_third_r ? sub_tick_w : 1'b1;
  wire tick4_w = sub_osc_select_fourth_r ? sub_tick_w : 1'b1;

  // ==============================================================
  // the two timer pairs; the mode nibble layout is the same for both
  tmrc_pair u_pair01 (
    .clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .mode_lo_in(mode01_r[3:0]),
    .mode_hi_in(mode01_r[7:4]),
    .run_lo_in(run_bit_zero_r),
    .run_hi_in(run_bit_one_r),
    .gate_pin_lo_in(external_interrupt_pin_in[0]),
    .gate_pin_hi_in(external_interrupt_pin_in[1]),
    .count_pin_lo_in(count_pin_in[0]),
    .count_pin_hi_in(count_pin_in[1]),
    .tick_lo_in(1'b1),
    .tick_hi_in(1'b1),
    .wr_byte_in(wr_b01_w),
    .wr_data_in(reg_wdata_in),
    .count_lo_out(cnt0_w),
    .count_hi_out(cnt1_w),
    .ovf_lo_out(ovf0_w),
    .ovf_hi_out(ovf1_w)
  );

  tmrc_pair u_pair34 (
    .clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .mode_lo_in(mode34_r[3:0]),
    .mode_hi_in(mode34_r[7:4]),
    .run_lo_in(run_bit_third_r),
    .run_hi_in(run_bit_fourth_r),
    .gate_pin_lo_in(external_interrupt_pin_in[2]),
    .gate_pin_hi_in(external_interrupt_pin_in[3]),
    .count_pin_lo_in(count_pin_in[2]),
    .count_pin_hi_in(count_pin_in[3]),
    .tick_lo_in(tick3_w),
    .tick_hi_in(tick4_w),
    .wr_byte_in(wr_b34_w),
    .wr_data_in(reg_wdata_in),
    .count_lo_out(cnt3_w),
    .count_hi_out(cnt4_w),
    .ovf_lo_out(ovf3_w),
    .ovf_hi_out(ovf4_w)
  );

  // ==============================================================
  // overflow flags: software may write them, acknowledge clears them,
  // and an overflow in the same cycle wins over both
  always @* begin
    flag_nxt = flag_r & ~vec_ack_in;
    if (wr_ctrl01_w) begin
      flag_nxt[0] = reg_wdata_in[`TMRC_BIT_TF_LO];
      flag_nxt[1] = reg_wdata_in[`TMRC_BIT_TF_HI];
    end
    if (wr_con34_w) begin
      flag_nxt[2] = reg_wdata_in[`TMRC_BIT_TF_LO];
      flag_nxt[3] = reg_wdata_in[`TMRC_BIT_TF_HI];
    end
    flag_nxt = flag_nxt | ovf_w;
  end

  // interrupt status: sticky, cleared by writing ones, set wins
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr_clr_w) begin
      irq_stat_nxt = irq_stat_r & ~reg_wdata_in[3:0];
    end
    irq_stat_nxt = irq_stat_nxt | ovf_w;
  end

  // ==============================================================
  // read mux; write-only and reserved bits read as zero
  always @* begin
    case (reg_addr_in)
      `TMRC_OFS_CTRL01: rd_val = {flag_r[1], run_bit_one_r, flag_r[0], run_bit_zero_r, 4'h0};
      `TMRC_OFS_MODE01: rd_val = mode01_r;
      `TMRC_OFS_CON34: rd_val = {flag_r[3], run_bit_fourth_r, flag_r[2], run_bit_third_r, 4'h0};
      `TMRC_OFS_MODE34: rd_val = mode34_r;
      `TMRC_OFS_T0_LO: rd_val = cnt0_w[7:0];
      `TMRC_OFS_T0_HI: rd_val = cnt0_w[15:8];
      `TMRC_OFS_T1_LO: rd_val = cnt1_w[7:0];
      `TMRC_OFS_T1_HI: rd_val = cnt1_w[15:8];
      `TMRC_OFS_T3_LO: rd_val = cnt3_w[7:0];
      `TMRC_OFS_T3_HI: rd_val = cnt3_w[15:8];
      `TMRC_OFS_T4_LO: rd_val = cnt4_w[7:0];
      `TMRC_OFS_T4_HI: rd_val = cnt4_w[15:8];
      `TMRC_OFS_IRQ_STAT: rd_val = {4'h0, irq_stat_r};
      `TMRC_OFS_IRQ_EN: rd_val = {4'h0, irq_en_r};
      default: rd_val = 8'h00;
    endcase
  end

  // ==============================================================
  // registers; reserved control bits are not stored, so a one written there
  // has no effect and reads back as zero
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode01_r <= `TMRC_RST_BYTE;
      mode34_r <= `TMRC_RST_BYTE;
      run_bit_zero_r <= 1'b0;
      run_bit_one_r <= 1'b0;
      run_bit_third_r <= 1'b0;
      run_bit_fourth_r <= 1'b0;
      sub_osc_select_third_r <= 1'b0;
      sub_osc_select_fourth_r <= 1'b0;
      flag_r <= `TMRC_RST_NIB;
      irq_stat_r <= `TMRC_RST_NIB;
      irq_en_r <= `TMRC_RST_NIB;
      sub_prev_r <= 1'b0;
      reg_rdata_out <= `TMRC_RST_BYTE;
      ovf_flag_out <= `TMRC_RST_NIB;
      irq_out <= 1'b0;
    end else begin
      if (wr_mode01_w) mode01_r <= reg_wdata_in;
      if (wr_mode34_w) mode34_r <= reg_wdata_in;
      if (wr_ctrl01_w) begin
        run_bit_zero_r <= reg_wdata_in[`TMRC_BIT_TR_LO];
        run_bit_one_r <= reg_wdata_in[`TMRC_BIT_TR_HI];
      end
      if (wr_con34_w) begin
        run_bit_third_r <= reg_wdata_in[`TMRC_BIT_TR_LO];
        run_bit_fourth_r <= reg_wdata_in[`TMRC_BIT_TR_HI];
        sub_osc_select_third_r <= reg_wdata_in[`TMRC_BIT_SUB_THIRD];
        sub_osc_select_fourth_r <= reg_wdata_in[`TMRC_BIT_SUB_FOURTH];
      end
      if (wr_en_w) irq_en_r <= reg_wdata_in[3:0];
      flag_r <= flag_nxt;
      irq_stat_r <= irq_stat_nxt;
      sub_prev_r <= sub_osc_in;
      // read data stands only in the cycle after the strobe
      reg_rdata_out <= reg_rd_in ? rd_val : 8'h00;
      ovf_flag_out <= flag_nxt;
      irq_out <= |(irq_stat_nxt & irq_en_r);
    end
  end

endmodule // tmrc_top

/* File: test/tmrc_chk.sv */
// tmrc_chk.sv: port assertions for the timer mode and run control block.
// assumes: one clock, asynchronous active-low reset, bound to tmrc_top below.
`timescale 1ns/100ps
module tmrc_chk (
  // clock and reset
  input wire sys_clk_in,
  input wire arst_n_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // acknowledge, flags, interrupt
  input wire [3:0] vec_ack_in,
  input wire [3:0] ovf_flag_out,
  input wire irq_out
);
  // ====================
  // register port checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its slot");
  a_con34_rsvd: assert property (reg_rd_in && reg_addr_in == 8'h90 |=> reg_rdata_out[3:0] == 4'h0)
    else $error("reserved or select bits read nonzero");
  a_ctrl01_low: assert property (reg_rd_in && reg_addr_in == 8'h88 |=> reg_rdata_out[3:0] == 4'h0)
    else $error("low control nibble read nonzero");
  a_unmapped_zero: assert property (reg_rd_in && reg_addr_in < 8'h88 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read nonzero");
  a_mode01_back: assert property (reg_wr_in && reg_addr_in == 8'h89 ##1 !reg_wr_in ##1
    reg_rd_in && reg_addr_in == 8'h89 |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("mode01 readback wrong");
  a_mode34_back: assert property (reg_wr_in && reg_addr_in == 8'h91 ##1 !reg_wr_in ##1
    reg_rd_in && reg_addr_in == 8'h91 |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("mode34 readback wrong");
  // ====================
  // flag and interrupt checks: a flag only drops on acknowledge or a write
  a_flag_stands: assert property (|($past(ovf_flag_out) & ~ovf_flag_out & ~$past(vec_ack_in))
    |-> $past(reg_wr_in))
    else $error("flag dropped without cause");
  a_irq_cause: assert property ($rose(irq_out) |-> |ovf_flag_out || $past(reg_wr_in) ||
    $past(reg_wr_in, 2))
    else $error("interrupt rose without cause");
  a_irq_mask: assert property (reg_wr_in && reg_addr_in == 8'haa && reg_wdata_in == 8'h00
    ##1 (!reg_wr_in) [*2] |-> !irq_out)
    else $error("masked interrupt still high");
  c_flag_irq: cover property (ovf_flag_out[0] && irq_out);
  c_pair34: cover property (|ovf_flag_out[3:2]);
  c_ack: cover property (vec_ack_in[0] ##1 !ovf_flag_out[0]);
endmodule // tmrc_chk

bind tmrc_top tmrc_chk tmrc_chk_inst (.sys_clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .vec_ack_in, .ovf_flag_out, .irq_out);

/* File: test/tmrc_pins.sv */
// tmrc_pins.sv: far-side pins: gate levels, count pulse trains, sub oscillator.
// assumes: driven by the bench clock; pulses are two cycles high, two low.
`timescale 1ns/100ps
module tmrc_pins (
  // clock
  input wire sys_clk_in,
  // requests from the bench
  input wire [3:0] gate_lvl_in,
  input wire [7:0] n_pulse_in,
  input wire go_in,
  // pins
  output logic [3:0] gate_pin_out,
  output logic [3:0] count_pin_out,
  output logic sub_osc_out,
  output logic busy_out
);
  int left = 0;
  int ph = 0;
  // idle low outside a train, so no stray falling step reaches the counter
  always @(posedge sys_clk_in) begin
    gate_pin_out <= gate_lvl_in;
    if (go_in) begin
      left <= n_pulse_in;
      ph <= 0;
    end else if (left != 0) begin
      ph <= (ph + 1) % 4;
      if (ph == 3)
        left <= left - 1;
    end
  end
  // one falling step and one rising step per pulse
  assign count_pin_out = {4{left != 0 && ph < 2}};
  assign sub_osc_out = left != 0 && ph < 2;
  assign busy_out = go_in || left != 0;
endmodule // tmrc_pins

/* File: test/tmrc_top_tb_top.sv */
// tmrc_top_tb_top.sv: self-checking bench for tmrc_top with a counting model.
// assumes: tmrc_pins drives the pins; 250 MHz clock.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tmrc_top_tb_top;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [3:0] vec_ack_in = 4'h0;
  logic [3:0] gate_lvl = 4'h0;
  logic [7:0] n_pulse = 8'h00;
  logic go = 1'b0;
  wire [7:0] reg_rdata_out;
  wire [3:0] ovf_flag_out, ext_pin, cnt_pin;
  wire irq_out, sub_osc, busy;
  int n_mismatch = 0;
  int cmp_count = 0;
  int lo, hi, f0, f1, k, n;
  logic [7:0] rd_val, b, d;
  logic [3:0] ef;
  always #2 sys_clk_in = ~sys_clk_in;
  tmrc_top tmrc_top_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .external_interrupt_pin_in(ext_pin),
    .count_pin_in(cnt_pin), .sub_osc_in(sub_osc), .vec_ack_in(vec_ack_in),
    .ovf_flag_out(ovf_flag_out), .irq_out(irq_out));
  tmrc_pins tmrc_pins_inst (.sys_clk_in(sys_clk_in), .gate_lvl_in(gate_lvl),
    .n_pulse_in(n_pulse), .go_in(go), .gate_pin_out(ext_pin), .count_pin_out(cnt_pin),
    .sub_osc_out(sub_osc), .busy_out(busy));
  // ====================
  // bus tasks, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    reg_addr_in <= a;
    reg_wdata_in <= dv;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    // one idle edge, so a following write never re-raises the strobe in this step
    @(posedge sys_clk_in);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    rd_val = reg_rdata_out;
    `CHK("rdata", e, rd_val)
    @(posedge sys_clk_in);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  task automatic ack(input logic [3:0] m);
    vec_ack_in <= m;
    @(posedge sys_clk_in);
    vec_ack_in <= 4'h0;
    @(posedge sys_clk_in);
  endtask
  task automatic pulses(input int c);
    n_pulse <= c[7:0];
    go <= 1'b1;
    @(posedge sys_clk_in);
    go <= 1'b0;
    repeat (400) if (busy) @(posedge sys_clk_in);
    // a pulse train that never ends is a hang of the far side
    if (busy) n_mismatch++;
    cyc(2);
  endtask
  // ====================
  // reference model: one count step of the lower timer and split high byte
  task automatic step(input int m);
    int c;
    case (m)
      0: begin
        c = (hi << 5 | lo & 31) + 1;
        f0 |= c >> 13;
        hi = c >> 5 & 255;
        lo = lo & 224 | c & 31;
      end
      1: begin
        c = (hi << 8 | lo) + 1;
        f0 |= c >> 16;
        hi = c >> 8 & 255;
        lo = c & 255;
      end
      2: begin
        f0 |= lo == 255;
        lo = lo == 255 ? hi : lo + 1;
      end
      default: begin
        f0 |= lo == 255;
        f1 |= hi == 255;
        lo = (lo + 1) & 255;
        hi = (hi + 1) & 255;
      end
    endcase
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog: the whole sequence needs about a thousand cycles
  initial begin
    cyc(20000);
    n_mismatch++;
    conclude();
  end
  // ====================
  // main sequence
  initial begin
    void'($urandom(32'h3b4c642a));
    cyc(10);
    arst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    rchk(8'h89, 8'h00);
    rchk(8'h91, 8'h00);
    wr(8'h10, 8'hff);
    rchk(8'h10, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(8'h89, d);
      rchk(8'h89, d);
      wr(8'h91, ~d);
      rchk(8'h91, ~d);
    end
    // flags stored by software, selects write-only, acknowledge clears
    wr(8'h90, 8'ha5);
    rchk(8'h90, 8'ha0);
    `CHK("flags", 4'hc, ovf_flag_out)
    ack(4'hc);
    `CHK("flags", 4'h0, ovf_flag_out)
    wr(8'h90, 8'h00);
    wr(8'ha9, 8'h0f);
    wr(8'haa, 8'h0f);
    // every mode on both pairs; stop write keeps the flags that are already set
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        lo = $urandom_range(255, 224);
        hi = m == 2 ? $urandom_range(255, 0) : 255;
        f0 = 0;
        f1 = 0;
        k = $urandom_range(60, 32);
        b = 8'ha0 + 8'(4 * p);
        wr(b, lo[7:0]);
        wr(b + 8'h1, hi[7:0]);
        wr(b + 8'h2, 8'h00);
        wr(b + 8'h3, 8'h00);
        wr(8'h89 + 8'(8 * p), m == 3 ? 8'h33 : 8'(m));
        wr(8'h88 + 8'(8 * p), m == 3 ? 8'h50 : 8'h10);
        cyc(k);
        wr(8'h88 + 8'(8 * p), m == 3 ? 8'ha0 : 8'h20);
        // counts from the edge after the start write through the stop write's
        // edge: k waited cycles plus the write task's idle edge plus one
        repeat (k + 2) step(m);
        rchk(b, lo[7:0]);
        rchk(b + 8'h1, hi[7:0]);
        rchk(b + 8'h2, 8'h00);
        rchk(b + 8'h3, 8'h00);
        ef = 4'(f1 << 1 | f0) << 2 * p;
        `CHK("flags", ef, ovf_flag_out)
        `CHK("irq", 1'b1, irq_out)
        rchk(8'ha8, {4'h0, ef});
        ack(ef);
        `CHK("flags", 4'h0, ovf_flag_out)
        wr(8'haa, 8'h00);
        cyc(2);
        `CHK("irq", 1'b0, irq_out)
        wr(8'haa, 8'h0f);
        wr(8'ha9, 8'h0f);
        cyc(2);
        `CHK("irq", 1'b0, irq_out)
      end
    end
    // gate on timer 3: low pin holds, high pin counts
    wr(8'h91, 8'h09);
    wr(8'ha4, 8'h00);
    wr(8'ha5, 8'h00);
    wr(8'h90, 8'h10);
    cyc(20);
    wr(8'h90, 8'h00);
    rchk(8'ha4, 8'h00);
    gate_lvl <= 4'h4;
    cyc(2);
    k = $urandom_range(40, 5);
    wr(8'h90, 8'h10);
    cyc(k);
    wr(8'h90, 8'h00);
    rchk(8'ha4, 8'(k + 2));
    // event counting on timer 0, then sub oscillator ticks on timer 3
    n = $urandom_range(20, 5);
    wr(8'h89, 8'h05);
    wr(8'ha0, 8'h00);
    wr(8'h88, 8'h10);
    pulses(n);
    wr(8'h88, 8'h00);
    rchk(8'ha0, 8'(n));
    wr(8'h91, 8'h01);
    wr(8'ha4, 8'h00);
    wr(8'h90, 8'h14);
    pulses(n);
    wr(8'h90, 8'h00);
    rchk(8'ha4, 8'(n));
    conclude();
  end
endmodule // tmrc_top_tb_top
